// ### vof_formatter.sv
// Purpose: output formatter placing pixels on a 24- or 48-bit bus with syncs
// Assumes: pixel clock is far slower than pclk (at least 4 pclk per half period)
// Notes: output clock is rebuilt from the sampled pixel clock edges
`timescale 1ns/10ps
module vof_formatter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pix_clk_in,
	input wire vof_pkg::vof_pix_t pix_data_in,
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	output vof_pkg::vof_pix_t prim_out,
	output logic [2:0] prim_oe_n,
	output vof_pkg::vof_pix_t sec_out,
	output logic [2:0] sec_oe_n,
	output logic pixel_output_clock,
	output logic pixel_output_clock_oe_n,
	output logic pixel_output_clock_n,
	output logic pixel_output_clock_n_oe_n,
	output logic line_sync_output,
	output logic frame_sync_output
);
	vof_pkg::vof_cfg_t cfg;
	vof_pkg::vof_pix_t pix_s;
	vof_pkg::vof_pix_t hold_ff;
	vof_pkg::vof_pix_t prim_ff;
	vof_pkg::vof_pix_t sec_ff;
	vof_pkg::vof_pix_t narrow_pix;
	vof_pkg::vof_slot_t slot_ff;
	vof_pkg::vof_slot_t nxt_slot;
	logic clk_s;
	logic ls_s;
	logic fs_s;
	logic clk_d_ff;
	logic ls_prev_ff;
	logic rise;
	logic fall;
	logic ls_lead;
	logic [7:0] ls_cnt_ff;
	logic [7:0] nxt_ls_cnt;
	logic [7:0] eff_width;
	logic pix_ls;
	logic ls_pend_ff;
	logic fs_pend_ff;
	logic ls_out_ff;
	logic fs_out_ff;
	logic dclk_ff;
	logic dclk_n_ff;
	logic change;
	logic wide;
	logic ilv;
	logic swap;
	logic f422;
	logic ckpol;
	logic to_sec;
	logic [7:0] status;

	// clamp keeps a too-small width from dropping the pulse
	function automatic logic [7:0] vof_eff_width(input logic [7:0] w, input logic wide_mode);
		logic [7:0] lim;
		lim = wide_mode ? vof_pkg::LS_MIN_WIDE : vof_pkg::LS_MIN_NARROW;
		return (w < lim) ? lim : w;
	endfunction

	vof_apb_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cfg(cfg),
		.status(status)
	);

	// data, syncs and clock share one sync depth so they stay aligned
	vof_sync #(
		.W(27)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({pix_clk_in, pix_data_in, line_sync_in, frame_sync_in}),
		.sync_out({clk_s, pix_s, ls_s, fs_s})
	);

	assign wide = cfg.fmt[vof_pkg::FMT_WIDE];
	assign ilv = cfg.fmt[vof_pkg::FMT_ILV];
	assign swap = cfg.fmt[vof_pkg::FMT_SWAP];
	assign f422 = cfg.fmt[vof_pkg::FMT_422];
	assign ckpol = cfg.fmt[vof_pkg::FMT_CKPOL];
	assign rise = clk_s && !clk_d_ff;
	assign fall = !clk_s && clk_d_ff;
	assign ls_lead = rise && ls_s && !ls_prev_ff;
	assign eff_width = vof_eff_width(cfg.ls_width, wide);
	assign status = {5'h00, dclk_ff, slot_ff, (ls_cnt_ff != 8'h00)};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clk_d_ff <= 1'b0;
		else
			clk_d_ff <= clk_s;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ls_prev_ff <= 1'b0;
		else if (rise)
			ls_prev_ff <= ls_s;
	end

	always_comb
	begin
		pix_ls = ls_lead || (ls_cnt_ff != 8'h00);
		if (ls_lead)
			nxt_ls_cnt = eff_width - 8'h01;
		else if (ls_cnt_ff != 8'h00)
			nxt_ls_cnt = ls_cnt_ff - 8'h01;
		else
			nxt_ls_cnt = 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ls_cnt_ff <= 8'h00;
		else if (rise)
			ls_cnt_ff <= nxt_ls_cnt;
	end

	// first pixel after line sync trailing edge is slot one
	always_comb
	begin
		if (pix_ls && (nxt_ls_cnt == 8'h00))
			nxt_slot = vof_pkg::SLOT_FIRST;
		else
			nxt_slot = (slot_ff == vof_pkg::SLOT_FIRST) ? vof_pkg::SLOT_SECOND
				: vof_pkg::SLOT_FIRST;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			slot_ff <= vof_pkg::SLOT_FIRST;
		else if (rise)
			slot_ff <= nxt_slot;
	end

	// change edge: every pixel narrow, pair end or primary slot wide
	always_comb
	begin
		if (!wide)
			change = 1'b1;
		else if (ilv)
			change = (slot_ff == vof_pkg::vof_slot_t'(swap));
		else
			change = (slot_ff == vof_pkg::SLOT_SECOND);
		to_sec = (slot_ff == vof_pkg::SLOT_SECOND) ^ swap;
	end

	// change edge level follows the polarity bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dclk_ff <= 1'b1;
			dclk_n_ff <= 1'b0;
		end
		else if (rise)
		begin
			dclk_ff <= change ? ckpol : !ckpol;
			dclk_n_ff <= change ? !ckpol : ckpol;
		end
		// wide mode toggles once per pixel, half pixel rate
		else if (fall && !wide)
		begin
			dclk_ff <= !ckpol;
			dclk_n_ff <= ckpol;
		end
	end

	// decimated chroma alternates on red, blue forced low
	always_comb
	begin
		narrow_pix = pix_s;
		if (f422)
		begin
			narrow_pix.r = (slot_ff == vof_pkg::SLOT_FIRST) ? pix_s.b : pix_s.r;
			narrow_pix.b = 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hold_ff <= '0;
		else if (rise && (slot_ff == vof_pkg::SLOT_FIRST))
			hold_ff <= pix_s;
	end

	// bus width selects primary only or both groups
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prim_ff <= '0;
			sec_ff <= '0;
		end
		else if (rise)
		begin
			if (!wide)
			begin
				prim_ff <= narrow_pix;
				sec_ff <= '0;
			end
			// interleaved: each group moves as its pixel arrives
			else if (ilv)
			begin
				if (to_sec)
					sec_ff <= pix_s;
				else
					prim_ff <= pix_s;
			end
			// pair lands together, swap picks the group of the first
			else if (change)
			begin
				prim_ff <= swap ? pix_s : hold_ff;
				sec_ff <= swap ? hold_ff : pix_s;
			end
		end
	end

	// syncs seen on a non-change pixel wait for the next change edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ls_pend_ff <= 1'b0;
			fs_pend_ff <= 1'b0;
		end
		else if (rise)
		begin
			ls_pend_ff <= change ? 1'b0 : (ls_pend_ff || pix_ls);
			fs_pend_ff <= change ? 1'b0 : (fs_pend_ff || fs_s);
		end
	end

	// polarity applied at the change edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ls_out_ff <= 1'b0;
			fs_out_ff <= 1'b0;
		end
		else if (rise && change)
		begin
			ls_out_ff <= (pix_ls || ls_pend_ff) ^ cfg.fmt[vof_pkg::FMT_LSPOL];
			fs_out_ff <= (fs_s || fs_pend_ff) ^ cfg.fmt[vof_pkg::FMT_FSPOL];
		end
	end

	// data held a full half period around the capture edge
	assign prim_out = prim_ff;
	assign sec_out = sec_ff;
	assign pixel_output_clock = dclk_ff;
	assign pixel_output_clock_n = dclk_n_ff;
	assign line_sync_output = ls_out_ff;
	assign frame_sync_output = fs_out_ff;
	// byte enables come straight from the disable bits
	assign prim_oe_n = {cfg.dis[vof_pkg::DIS_RP], cfg.dis[vof_pkg::DIS_GP],
		cfg.dis[vof_pkg::DIS_BP]};
	assign sec_oe_n = {cfg.dis[vof_pkg::DIS_RS], cfg.dis[vof_pkg::DIS_GS],
		cfg.dis[vof_pkg::DIS_BS]};
	assign pixel_output_clock_oe_n = cfg.dis[vof_pkg::DIS_CLK];
	assign pixel_output_clock_n_oe_n = cfg.dis[vof_pkg::DIS_CLK_N];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_NARROW_SEC_LOW: assert property ((rise && !wide) |=> sec_out == '0)
		else $error("secondary bytes not low in narrow mode");
	AST_SAME_EDGE: assert property ((rise && wide && !ilv && !change) |=> $stable(sec_out))
		else $error("secondary moved off the shared edge");
	AST_ILV_PRIM_EDGE: assert property ((rise && wide && ilv && !change) |=> $stable(prim_out))
		else $error("primary moved on the opposite edge");
	AST_SWAP_ORDER: assert property ((rise && wide && !ilv && change && !swap)
		|=> prim_out == $past(hold_ff) && sec_out == $past(pix_s))
		else $error("first pixel of pair not on primary");
	AST_422_BLUE: assert property ((rise && !wide && f422) |=> prim_out.b == 8'h00)
		else $error("blue not low in 4:2:2");
	AST_CLK_POL: assert property ((rise && change) |=> pixel_output_clock == $past(ckpol)
		&& pixel_output_clock_n != pixel_output_clock)
		else $error("output clock level wrong at change edge");
	AST_LS_POL: assert property ((rise && change) |=> line_sync_output ==
		($past(pix_ls || ls_pend_ff) ^ $past(cfg.fmt[vof_pkg::FMT_LSPOL])))
		else $error("line sync level or polarity wrong");
	AST_FS_POL: assert property ((rise && change) |=> frame_sync_output ==
		($past(fs_s || fs_pend_ff) ^ $past(cfg.fmt[vof_pkg::FMT_FSPOL])))
		else $error("frame sync level or polarity wrong");
	AST_LS_WIDTH: assert property (ls_lead |=> ls_cnt_ff == $past(eff_width) - 8'h01)
		else $error("line sync width count wrong");
	AST_LS_MIN: assert property (eff_width >= (wide ? 8'h02 : 8'h01))
		else $error("line sync width below minimum");
	AST_OE_MAP: assert property (prim_oe_n[2] == cfg.dis[0] && sec_oe_n[0] == cfg.dis[5])
		else $error("byte enable mapping wrong");
	AST_OE_PRIO: assert property ($changed(cfg.fmt) |-> $stable(prim_oe_n))
		else $error("format change moved a byte enable");
	AST_CLK_OE: assert property (pixel_output_clock_oe_n == cfg.dis[7]
		&& pixel_output_clock_n_oe_n == cfg.dis[6])
		else $error("clock enable mapping wrong");
	AST_HALF_RATE: assert property ((fall && wide) |=> $stable(pixel_output_clock))
		else $error("wide mode clock moved on pixel falling edge");
	AST_ILV_SEC_EDGE: assert property ((rise && wide && ilv && change)
		|=> $stable(sec_out))
		else $error("secondary moved on the primary edge");
	AST_NARROW_FALL: assert property ((fall && !wide)
		|=> pixel_output_clock == !$past(ckpol))
		else $error("narrow clock not back at capture level after pixel fall");
	AST_422_RED: assert property ((rise && !wide && f422
		&& slot_ff == vof_pkg::SLOT_FIRST) |=> prim_out.r == $past(pix_s.b))
		else $error("first 4:2:2 slot does not carry blue on red");

	COV_WIDE_ILV: cover property (rise && wide && ilv && to_sec);
	COV_WIDE_SWAP: cover property (rise && wide && !ilv && swap && change);
	COV_NARROW_422: cover property (rise && !wide && f422);
	COV_LS_END: cover property (rise && pix_ls && nxt_ls_cnt == 8'h00);
	COV_NARROW_RISE_POL: cover property (rise && !wide && ckpol);
endmodule

// ### vof_pkg.sv
// Purpose: constants and types of the video output formatter
// Assumes: registers hold 8 bits, one per aligned 32-bit APB word at 4 x index
// Notes: shared by the formatter top, its register slave, the receiver model and the bench
package vof_pkg;
	localparam logic [7:0] IDX_FORMAT = 8'h18;
	localparam logic [7:0] IDX_LS_WIDTH = 8'h19;
	localparam logic [7:0] IDX_DISABLE = 8'h1A;
	localparam logic [7:0] IDX_STATUS = 8'h1F;
	localparam logic [7:0] RST_FORMAT = 8'h00;
	localparam logic [7:0] RST_LS_WIDTH = 8'h10;
	localparam logic [7:0] RST_DISABLE = 8'h00;
	localparam logic [7:0] FORMAT_RW_MASK = 8'hF7;
	localparam int FMT_WIDE = 0;
	localparam int FMT_ILV = 1;
	localparam int FMT_SWAP = 2;
	localparam int FMT_422 = 4;
	localparam int FMT_CKPOL = 5;
	localparam int FMT_FSPOL = 6;
	localparam int FMT_LSPOL = 7;
	localparam int DIS_RP = 0;
	localparam int DIS_RS = 1;
	localparam int DIS_GP = 2;
	localparam int DIS_GS = 3;
	localparam int DIS_BP = 4;
	localparam int DIS_BS = 5;
	localparam int DIS_CLK_N = 6;
	localparam int DIS_CLK = 7;
	localparam logic [7:0] LS_MIN_NARROW = 8'h01;
	localparam logic [7:0] LS_MIN_WIDE = 8'h02;
	localparam int SYNC_STAGES = 2;
	typedef struct packed {
		logic [7:0] fmt;
		logic [7:0] ls_width;
		logic [7:0] dis;
	} vof_cfg_t;
	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} vof_pix_t;
	typedef enum logic {
		SLOT_FIRST = 1'b0,
		SLOT_SECOND = 1'b1
	} vof_slot_t;
endpackage

// ### vof_sync.sv
// Purpose: two-stage synchroniser for a vector of pin inputs
// Assumes: bits are independent levels; words must be stable across capture
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module vof_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule

// ### vof_apb_regs.sv
// Purpose: APB slave holding the formatter configuration registers
// Assumes: zero wait states; read data latched in the setup cycle
// Notes: unmapped or unaligned access answers pslverr, reads zero, writes dropped
`timescale 1ns/10ps
module vof_apb_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output vof_pkg::vof_cfg_t cfg,
	input wire logic [7:0] status
);
	vof_pkg::vof_cfg_t cfg_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic [7:0] rd_byte;
	logic hit;
	logic [5:0] idx;

	assign idx = paddr[7:2];

	always_comb
	begin
		hit = 1'b1;
		rd_byte = 8'h00;
		if (paddr[1:0] != 2'h0)
			hit = 1'b0;
		else if ({2'h0, idx} == vof_pkg::IDX_FORMAT)
			rd_byte = cfg_ff.fmt;
		else if ({2'h0, idx} == vof_pkg::IDX_LS_WIDTH)
			rd_byte = cfg_ff.ls_width;
		else if ({2'h0, idx} == vof_pkg::IDX_DISABLE)
			rd_byte = cfg_ff.dis;
		else if ({2'h0, idx} == vof_pkg::IDX_STATUS)
			rd_byte = status;
		else
			hit = 1'b0;
	end

	// answer prepared in setup so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata_ff <= (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			pslverr_ff <= !hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_ff.fmt <= vof_pkg::RST_FORMAT;
			cfg_ff.ls_width <= vof_pkg::RST_LS_WIDTH;
			cfg_ff.dis <= vof_pkg::RST_DISABLE;
		end
		else if (psel && penable && pwrite && hit)
		begin
			if ({2'h0, idx} == vof_pkg::IDX_FORMAT)
				cfg_ff.fmt <= pwdata[7:0] & vof_pkg::FORMAT_RW_MASK;
			if ({2'h0, idx} == vof_pkg::IDX_LS_WIDTH)
				cfg_ff.ls_width <= pwdata[7:0];
			if ({2'h0, idx} == vof_pkg::IDX_DISABLE)
				cfg_ff.dis <= pwdata[7:0];
		end
	end

	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;
	assign pready = 1'b1;
	assign cfg = cfg_ff;
endmodule

// ### vof_rx_model.sv
// Purpose: downstream receiver model that captures the primary bytes
// Assumes: data pins have pulldowns, so a three-stated byte reads low
// Notes: capture edge follows the output clock polarity setting
`timescale 1ns/10ps
module vof_rx_model (
	input wire logic ckpol,
	input wire logic clk_out,
	input wire vof_pkg::vof_pix_t prim_out,
	input wire logic [2:0] prim_oe_n,
	output vof_pkg::vof_pix_t cap_pix
);
	vof_pkg::vof_pix_t wire_pix;
	// released byte falls to the pulldown level
	assign wire_pix.r = prim_oe_n[2] ? 8'h00 : prim_out.r;
	assign wire_pix.g = prim_oe_n[1] ? 8'h00 : prim_out.g;
	assign wire_pix.b = prim_oe_n[0] ? 8'h00 : prim_out.b;
	always @(clk_out)
	begin
		if (clk_out != ckpol)
			cap_pix = wire_pix;
	end
endmodule

// ### testbench.sv
// Purpose: self-checking bench of the video output formatter
// Assumes: pixel clock paused low between checks, outside active traffic
// Notes: expected values come from the register settings the bench writes
`timescale 1ns/10ps
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pix_clk_in, line_sync_in, frame_sync_in;
	logic [7:0] paddr, fmt;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, ck, ckn, ck_oe_n, ckn_oe_n, ls_o, fs_o, pclk_chg, sclk_chg;
	logic [2:0] p_oe_n, s_oe_n;
	vof_pkg::vof_pix_t pix_data_in, prim_out, sec_out, cap_pix;
	int n_fail, compares;
	vof_formatter i_vof_formatter (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pix_clk_in(pix_clk_in), .pix_data_in(pix_data_in),
		.line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in), .prim_out(prim_out),
		.prim_oe_n(p_oe_n), .sec_out(sec_out), .sec_oe_n(s_oe_n), .pixel_output_clock(ck),
		.pixel_output_clock_oe_n(ck_oe_n), .pixel_output_clock_n(ckn),
		.pixel_output_clock_n_oe_n(ckn_oe_n), .line_sync_output(ls_o),
		.frame_sync_output(fs_o));
	vof_rx_model i_vof_rx_model (.ckpol(fmt[5]), .clk_out(ck), .prim_out(prim_out),
		.prim_oe_n(p_oe_n), .cap_pix(cap_pix));
	always #12.5 pclk = ~pclk;
	// clock level seen just after each data change
	always @(prim_out) #1 pclk_chg = ck;
	always @(sec_out) #1 sclk_chg = ck;
	task automatic close_out;
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, 32'(d), q, e);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
		chk(32'(e), 32'(ee));
	endtask
	task automatic set_fmt(input logic [7:0] v);
		fmt = v;
		wr(8'h60, v);
	endtask
	// one pixel at 200 ns: data, 4 pclk low, 4 pclk high
	task automatic px(input vof_pkg::vof_pix_t p, input logic [1:0] s);
		pix_data_in <= p;
		line_sync_in <= s[0];
		frame_sync_in <= s[1];
		repeat (4) @(posedge pclk);
		pix_clk_in <= 1'b1;
		repeat (4) @(posedge pclk);
		pix_clk_in <= 1'b0;
	endtask
	task automatic st;
		repeat (6) @(posedge pclk);
	endtask
	task automatic t_regs;
		chk(32'({ck, ckn, ls_o, fs_o}), 32'h8);
		rc(8'h7C, 32'h4, 1'b0);
		rc(8'h60, 32'h0, 1'b0);
		rc(8'h64, 32'h10, 1'b0);
		rc(8'h68, 32'h0, 1'b0);
		wr(8'h60, 8'hFF);
		rc(8'h60, 32'hF7, 1'b0);
		wr(8'h64, 8'hA5);
		rc(8'h64, 32'hA5, 1'b0);
		rc(8'h70, 32'h0, 1'b1);
		rc(8'h61, 32'h0, 1'b1);
		wr(8'h64, 8'h01);
	endtask
	task automatic t_narrow;
		set_fmt(8'h00);
		px(24'h123456, 2'b00);
		st;
		chk(32'(prim_out), 32'h123456);
		chk(32'(sec_out), 32'h0);
		chk(32'(cap_pix), 32'h123456);
		chk(32'(pclk_chg), 32'h0);
		chk(32'(ckn), 32'(!ck));
		set_fmt(8'hE0);
		px(24'h654321, 2'b11);
		st;
		chk(32'(pclk_chg), 32'h1);
		chk(32'(cap_pix), 32'h654321);
		chk(32'({ls_o, fs_o}), 32'h0);
		px(24'h0F0F0F, 2'b00);
		st;
		chk(32'({ls_o, fs_o}), 32'h3);
	endtask
	task automatic t_width(input logic [7:0] w, input int n);
		int cnt;
		cnt = 0;
		wr(8'h64, w);
		set_fmt(8'h00);
		for (int i = 0; i < 6; i++)
		begin
			px(24'(i), 2'(i == 0));
			st;
			if (ls_o === 1'b1)
				cnt++;
		end
		chk(32'(cnt), 32'(n));
	endtask
	task automatic t_422;
		wr(8'h64, 8'h01);
		set_fmt(8'h10);
		px(24'h0, 2'b01);
		px(24'hA1B2C3, 2'b00);
		st;
		chk(32'(prim_out), 32'hC3B200);
		px(24'hD4E5F6, 2'b00);
		st;
		chk(32'(prim_out), 32'hD4E500);
	endtask
	task automatic t_wide(input logic [7:0] f);
		wr(8'h64, 8'h02);
		set_fmt(f);
		px(24'h0, 2'b01);
		px(24'h111111, 2'b00);
		px(24'hA1A2A3, 2'b00);
		st;
		if (f[1])
			chk(32'(prim_out), 32'hA1A2A3);
		px(24'hB1B2B3, 2'b00);
		st;
		chk(32'(prim_out), f[2] ? 32'hB1B2B3 : 32'hA1A2A3);
		chk(32'(sec_out), f[2] ? 32'hA1A2A3 : 32'hB1B2B3);
		chk(32'(sclk_chg), 32'(f[1]));
	endtask
	task automatic t_tri;
		logic [7:0] d;
		set_fmt(8'h01);
		for (int i = 0; i < 8; i++)
		begin
			d = 8'h01 << i;
			wr(8'h68, d);
			chk(32'({p_oe_n, s_oe_n, ck_oe_n, ckn_oe_n}),
				32'({d[0], d[2], d[4], d[1], d[3], d[5], d[7], d[6]}));
		end
		set_fmt(8'h00);
		wr(8'h68, 8'h01);
		px(24'hABCDEF, 2'b00);
		st;
		chk(32'(cap_pix), 32'h00CDEF);
		wr(8'h68, 8'h00);
	endtask
	// generous limit; the tests take well under a tenth of it
	initial
	begin
		#2000000;
		n_fail++;
		close_out;
	end
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, pix_clk_in, line_sync_in, frame_sync_in} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		pix_data_in = 24'h0;
		fmt = 8'h00;
		n_fail = 0;
		compares = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_regs;
		t_narrow;
		t_width(8'h03, 3);
		t_width(8'h00, 1);
		t_422;
		t_wide(8'h01);
		t_wide(8'h05);
		t_wide(8'h03);
		t_tri;
		close_out;
	end
endmodule
